// File: led_ctrl_port.sv
/*
  control-word interpreter and display ram of an 8-digit led driver,
  with an ahb-lite read port onto its state.
  assumes host pins synchronous to hclk; hready is this slave's hreadyout.
*/
`timescale 1ns/1ps
module led_ctrl_port #(
  parameter int DIGITS = led_ctrl_pkg::DIGITS
) (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output      logic                       hreadyout,
  output      logic                       hresp,
  output      logic [31:0]                hrdata,
  // host write port
  input  wire logic                       write_strobe,
  input  wire logic                       mode_select,
  input  wire led_ctrl_pkg::input_lines_t data_in,
  // display side
  output      logic                       osc_enable,
  output      logic                       display_blank,
  output      logic                       font_select,
  output      logic                       no_decode,
  output      logic                       bank_b_shown,
  output      logic [DIGITS-1:0][7:0]     shown_digits,
  output      logic [DIGITS-1:0]          decimal_point_bit,
  output      logic                       burst_busy
);

  if (DIGITS != 8) begin : g_chk
    $error("led_ctrl_port: digit address is three bits, DIGITS must be 8");
  end

  // ****************************************
  // state
  // ****************************************
  led_ctrl_pkg::wr_event_t   wr_evt;
  led_ctrl_pkg::ctrl_word_t  ctrl_r;
  led_ctrl_pkg::ctrl_word_t  ctrl_nxt;
  led_ctrl_pkg::upd_state_t  state_r;
  led_ctrl_pkg::upd_state_t  state_nxt;
  logic [3:0]                cnt_r;
  logic [3:0]                cnt_nxt;
  logic [1:0][DIGITS-1:0][7:0] ram_r;
  logic [1:0][DIGITS-1:0][7:0] ram_nxt;
  logic                      wr_ok;
  logic                      wr_bank;
  logic [2:0]                wr_idx;
  logic [31:0]               rdata_r;
  logic [31:0]               rdata_nxt;

  // bank index 0 is bank a; raw segment mode always uses bank a
  function automatic logic bank_of(input led_ctrl_pkg::ctrl_word_t c);
    return !c.no_decode && !c.bank_a;
  endfunction

  strobe_capture u_cap (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .write_strobe (write_strobe),
    .mode_select  (mode_select),
    .data_in      (data_in),
    .wr_evt       (wr_evt)
  );

  // ****************************************
  // interpreter
  // ****************************************
  always_comb begin
    ctrl_nxt  = ctrl_r;
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ram_nxt   = ram_r;
    wr_bank   = bank_of(ctrl_r);
    wr_idx    = (state_r == led_ctrl_pkg::ST_BURST) ? cnt_r[2:0] : ctrl_r.digit_addr;
    wr_ok     = wr_evt.valid && !wr_evt.to_ctrl && (state_r != led_ctrl_pkg::ST_DONE);
    if (wr_evt.valid && wr_evt.to_ctrl) begin
      ctrl_nxt = led_ctrl_pkg::ctrl_word_t'(wr_evt.lines);
      cnt_nxt  = led_ctrl_pkg::CNT_RESET;
      state_nxt = wr_evt.lines.burst_flag_line ? led_ctrl_pkg::ST_BURST
                                               : led_ctrl_pkg::ST_SINGLE;
    end
    if (wr_ok) begin
      ram_nxt[wr_bank][wr_idx] = wr_evt.lines;
      case (state_r)
        led_ctrl_pkg::ST_BURST: begin
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == led_ctrl_pkg::BURST_LAST) begin
            state_nxt = led_ctrl_pkg::ST_DONE;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r  <= led_ctrl_pkg::CTRL_RESET;
      state_r <= led_ctrl_pkg::ST_SINGLE;
      cnt_r   <= led_ctrl_pkg::CNT_RESET;
      ram_r   <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ram_r   <= ram_nxt;
    end
  end

  // ****************************************
  // display side
  // ****************************************
  // shutdown stops oscillator
  assign osc_enable    = ctrl_r.normal_power;
  assign display_blank = !ctrl_r.normal_power;
  assign font_select   = ctrl_r.font_select;
  assign no_decode     = ctrl_r.no_decode;
  assign bank_b_shown  = bank_of(ctrl_r);
  assign shown_digits  = ram_r[bank_of(ctrl_r)];
  assign burst_busy    = (state_r == led_ctrl_pkg::ST_BURST);

  always_comb begin
    for (int i = 0; i < DIGITS; i++) begin
      decimal_point_bit[i] = ram_r[bank_of(ctrl_r)][i][7];
    end
  end

  // ****************************************
  // ahb-lite read port
  // ****************************************
  // zero wait state; writes accepted and dropped, the pins own the state
  always_comb begin
    rdata_nxt = rdata_r;
    if (hsel && htrans[1] && hready && !hwrite) begin
      rdata_nxt = 32'h0000_0000;
      if (haddr[11:0] == led_ctrl_pkg::OFS_CTRL) begin
        rdata_nxt[7:0] = ctrl_r;
      end else if (haddr[11:0] == led_ctrl_pkg::OFS_STATUS) begin
        rdata_nxt[5:0] = {state_r, cnt_r};
      end else if (haddr[11:0] >= led_ctrl_pkg::OFS_BANK_A &&
                   haddr[11:0] < led_ctrl_pkg::OFS_BANK_B + led_ctrl_pkg::BANK_SPAN) begin
        rdata_nxt[7:0] = ram_r[haddr[6]][haddr[4:2]];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // checks
  // ****************************************
  a_ctrl_load_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_evt.valid && wr_evt.to_ctrl |=> ctrl_r == $past(wr_evt.lines))
    else $error("control word not loaded");
  a_ram_keeps_ctrl: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_evt.valid && !wr_evt.to_ctrl |=> $stable(ctrl_r))
    else $error("ram write changed control word");
  a_power_blank: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_evt.valid && wr_evt.to_ctrl && !wr_evt.lines.power_select_line
      |=> display_blank && !osc_enable)
    else $error("shutdown not applied");
  a_ram_data_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ok |=> ram_r[$past(wr_bank)][$past(wr_idx)] == $past(wr_evt.lines))
    else $error("ram byte not stored");
  a_single_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ok && state_r == led_ctrl_pkg::ST_SINGLE
      |=> ram_r[$past(wr_bank)][$past(ctrl_r.digit_addr)] == $past(wr_evt.lines))
    else $error("single digit address wrong");
  a_bank_select: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ok && (ctrl_r.no_decode || ctrl_r.bank_a) |=> $stable(ram_r[1]))
    else $error("bank selection wrong");
  a_font_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_evt.valid && wr_evt.to_ctrl |=> font_select == $past(wr_evt.lines.font_select_line))
    else $error("font select not taken");
  a_raw_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_evt.valid && wr_evt.to_ctrl && wr_evt.lines.translation_select_line
      |=> no_decode && !bank_b_shown)
    else $error("raw segment mode not taken");
  a_burst_start: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_evt.valid && wr_evt.to_ctrl |=> burst_busy == $past(wr_evt.lines.burst_flag_line)
      && cnt_r == led_ctrl_pkg::CNT_RESET)
    else $error("burst state wrong after control word");
  a_edge_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(write_strobe) && mode_select |=> ##1 ctrl_r == $past(data_in, 2))
    else $error("strobe edge not captured");
  a_burst_end: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ok && burst_busy && cnt_r == led_ctrl_pkg::BURST_LAST
      |=> state_r == led_ctrl_pkg::ST_DONE)
    else $error("burst did not end after eight");
  a_done_ignores: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == led_ctrl_pkg::ST_DONE && wr_evt.valid && !wr_evt.to_ctrl |=> $stable(ram_r))
    else $error("ram written after burst");

  c_burst_full: cover property (@(posedge hclk) disable iff (!hresetn)
    burst_busy ##1 state_r == led_ctrl_pkg::ST_DONE);
  c_single_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_ok && state_r == led_ctrl_pkg::ST_SINGLE);
  c_shutdown: cover property (@(posedge hclk) disable iff (!hresetn) display_blank);
  c_bus_read: cover property (@(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && !hwrite);

endmodule

// File: led_ctrl_pkg.sv
/*
  shared constants and carriers of the led display control-word port:
  input line layout, control word layout, reset values, register map.
  assumes a 32-bit ahb-lite fabric with word-aligned single transfers.
*/
package led_ctrl_pkg;

  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int          DIGITS      = 8;
  localparam int          DIG_AW      = 3;
  localparam logic [7:0]  CTRL_RESET  = 8'h10;
  localparam logic [3:0]  BURST_LAST  = 4'h7;
  localparam logic [3:0]  CNT_RESET   = 4'h0;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_BANK_A  = 12'h020;
  localparam logic [11:0] OFS_BANK_B  = 12'h040;
  localparam logic [11:0] BANK_SPAN   = 12'h020;

  // ****************************************
  // carriers
  // ****************************************
  // the eight input lines, msb first
  typedef struct packed {
    logic       burst_flag_line;
    logic       font_select_line;
    logic       translation_select_line;
    logic       power_select_line;
    logic       bank_select_line;
    logic       input_line_2;
    logic       input_line_1;
    logic       input_line_0;
  } input_lines_t;

  // control word as held after a control write
  typedef struct packed {
    logic              burst_follows;
    logic              font_select;
    logic              no_decode;
    logic              normal_power;
    logic              bank_a;
    logic [DIG_AW-1:0] digit_addr;
  } ctrl_word_t;

  // one captured write from the strobe edge
  typedef struct packed {
    logic         valid;
    logic         to_ctrl;
    input_lines_t lines;
  } wr_event_t;

  typedef enum logic [1:0] {ST_SINGLE, ST_BURST, ST_DONE} upd_state_t;

endpackage

// File: strobe_capture.sv
/*
  rising-edge detector for the host write strobe; takes the select and
  input lines in the cycle of the edge and hands them on as one event.
  assumes strobe, select and lines synchronous to hclk.
*/
`timescale 1ns/1ps
module strobe_capture (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // host pins
  input  wire logic                       write_strobe,
  input  wire logic                       mode_select,
  input  wire led_ctrl_pkg::input_lines_t data_in,
  // captured write
  output      led_ctrl_pkg::wr_event_t    wr_evt
);

  logic                    strobe_r;
  logic                    strobe_nxt;
  led_ctrl_pkg::wr_event_t evt_r;
  led_ctrl_pkg::wr_event_t evt_nxt;

  // ****************************************
  // edge detect and capture
  // ****************************************
  always_comb begin
    strobe_nxt     = write_strobe;
    evt_nxt        = evt_r;
    evt_nxt.valid  = 1'b0;
    if (write_strobe && !strobe_r) begin
      evt_nxt.valid   = 1'b1;
      evt_nxt.to_ctrl = mode_select;
      evt_nxt.lines   = data_in;
    end
  end

  // strobe history resets high: a strobe already high at release is no edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_r <= 1'b1;
      evt_r    <= '0;
    end else begin
      strobe_r <= strobe_nxt;
      evt_r    <= evt_nxt;
    end
  end

  assign wr_evt = evt_r;

endmodule

// File: host_model.sv
/*
  host model: drives write strobe, select and input lines of the port.
  assumes the bench calls put() from its main sequence, off reset.
*/
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic                  hclk,
  // host pins
  output logic                       write_strobe,
  output logic                       mode_select,
  output led_ctrl_pkg::input_lines_t data_in
);
  initial begin
    write_strobe = 1'h0;
    mode_select  = 1'h0;
    data_in      = 8'h00;
  end
  // select and lines held across the strobe edge
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge hclk);
    write_strobe <= 1'h1;
    mode_select  <= sel;
    data_in      <= d;
    @(posedge hclk);
    // hold time over: show inverse so a late sample is caught
    write_strobe <= 1'h0;
    mode_select  <= ~sel;
    data_in      <= ~d;
    @(posedge hclk);
  endtask
endmodule

// File: led_ctrl_port_test.sv
/*
  self-checking bench of the led control-word port: host writes through
  the host model, state read back over ahb-lite.
  assumes hready of the bus is the slave's hreadyout.
*/
`timescale 1ns/1ps
module led_ctrl_port_test;
  logic                       hclk, hresetn, hsel, hwrite;
  logic [31:0]                haddr, hwdata, hrdata, rv;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  logic                       hreadyout, hresp, osc_enable, display_blank;
  logic                       font_select, no_decode, bank_b_shown, burst_busy;
  logic                       write_strobe, mode_select;
  led_ctrl_pkg::input_lines_t data_in;
  logic [7:0][7:0]            shown_digits;
  logic [7:0]                 decimal_point_bit, cw, w, d;
  logic [7:0]                 ram_a [8];
  logic [7:0]                 ram_b [8];
  logic [2:0]                 a;
  int                         err_total, comparisons, seed;

  led_ctrl_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .write_strobe(write_strobe),
    .mode_select(mode_select), .data_in(data_in), .osc_enable(osc_enable),
    .display_blank(display_blank), .font_select(font_select), .no_decode(no_decode),
    .bank_b_shown(bank_b_shown), .shown_digits(shown_digits),
    .decimal_point_bit(decimal_point_bit), .burst_busy(burst_busy));
  host_model u_host (.hclk(hclk), .write_strobe(write_strobe),
    .mode_select(mode_select), .data_in(data_in));

  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // one write, then wait until state has landed (edge + 2)
  task automatic wr(input logic sel, input logic [7:0] v);
    u_host.put(sel, v);
    @(posedge hclk);
    #1;
  endtask
  task automatic rd(input logic [11:0] ad, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge hclk);
    haddr  <= {20'h00000, ad};
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    htrans <= 2'h0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    v = hrdata;
    if (n >= 100) chk(32'h0, 32'h1, "ahb wait timeout");
    #1;
  endtask
  function automatic logic [4:0] exp_out(input logic [7:0] c);
    return {c[4], ~c[4], c[6], c[5], ~c[5] & ~c[3]};
  endfunction
  function automatic logic [7:0] exp_dig(input int k);
    return (~cw[5] & ~cw[3]) ? ram_b[k] : ram_a[k];
  endfunction
  task automatic chk_digits;
    for (int k = 0; k < 8; k++) begin
      chk(shown_digits[k], exp_dig(k), "digit byte");
      chk(decimal_point_bit[k], exp_dig(k) >> 7, "decimal point");
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 70;
    hresetn = 1'h0;
    hsel = 1'h1;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    cw = led_ctrl_pkg::CTRL_RESET;
    for (int k = 0; k < 8; k++) begin
      ram_a[k] = 8'h00;
      ram_b[k] = 8'h00;
    end
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    #1;
    chk({osc_enable, display_blank, font_select, no_decode, bank_b_shown},
        exp_out(cw), "reset outputs");
    chk({hresp, burst_busy}, 2'h0, "reset status");
    rd(led_ctrl_pkg::OFS_CTRL, rv);
    chk(rv, 32'h10, "reset control");
    rd(12'h0FC, rv);
    chk(rv, 32'h0, "unmapped read");
    rd(led_ctrl_pkg::OFS_STATUS, rv);
    chk(rv, 32'h0, "reset status word");
    $display("test reset done");
    // control words, corners then random, burst flag low
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($random(seed)) & 8'h7F;
      wr(1'h1, w);
      cw = w;
      chk({osc_enable, display_blank, font_select, no_decode, bank_b_shown},
          exp_out(w), "control fields");
      rd(led_ctrl_pkg::OFS_CTRL, rv);
      chk(rv, {24'h0, w}, "control readback");
    end
    $display("test control done");
    // single-digit updates, bank alternating, raw mode among them
    for (int i = 0; i < 16; i++) begin
      a = 3'($random(seed));
      w = {3'h0, 1'h1, 1'(i), a} | ((i % 5 == 4) ? 8'h20 : 8'h00);
      wr(1'h1, w);
      cw = w;
      d = 8'($random(seed));
      wr(1'h0, d);
      if (~w[5] & ~w[3]) ram_b[a] = d;
      else ram_a[a] = d;
      chk_digits();
    end
    rd(led_ctrl_pkg::OFS_BANK_B + {7'h00, a, 2'h0}, rv);
    chk(rv, {24'h0, ram_b[a]}, "bank b readback");
    $display("test single done");
    // burst of eight into bank b, ninth write refused
    wr(1'h1, 8'h90);
    cw = 8'h90;
    chk(burst_busy, 1'h1, "burst busy");
    for (int k = 0; k < 9; k++) begin
      d = (k == 0) ? 8'hFF : 8'($random(seed));
      wr(1'h0, d);
      if (k < 8) ram_b[k] = d;
    end
    chk(burst_busy, 1'h0, "burst end");
    chk_digits();
    rd(led_ctrl_pkg::OFS_STATUS, rv);
    chk(rv, {26'h0000000, 2'h2, 4'h8}, "burst done status");
    $display("test burst done");
    end_sim();
  end
endmodule
